/* design/psp_pkg.sv */
// shared constants for the pipelined sram pin-control block
// assumes one clock domain; the controller drives pins on the rising edge
`default_nettype none

package psp_pkg;

  // ==========================================================
  // word layout: four 9-bit lanes, data bits low, parity bits high
  localparam int PSP_DATA_W   = 32;
  localparam int PSP_PAR_W    = 4;
  localparam int PSP_LANES    = 4;
  localparam int PSP_BYTE_W   = 8;
  localparam int PSP_WORD_W   = PSP_DATA_W + PSP_PAR_W;
  localparam int PSP_ADDR_W   = 18;

  // ==========================================================
  // burst and pipeline
  localparam int PSP_CNT_W    = 2;
  localparam int PSP_PIPE_LAT = 2;
  localparam int PSP_FIFO_DEPTH = 8;
  localparam int PSP_SYNC_STAGES = 2;

  // ==========================================================
  // values after reset
  localparam logic [PSP_CNT_W-1:0]  PSP_CNT_RST  = 2'h0;
  localparam logic [PSP_LANES-1:0]  PSP_BW_NONE  = 4'hf;
  localparam logic [PSP_WORD_W-1:0] PSP_WORD_RST = 36'h0;

  // low burst address bits: xor for interleaved, add modulo four for linear
  function automatic logic [PSP_CNT_W-1:0] psp_burst_low(
    input logic [PSP_CNT_W-1:0] base,
    input logic [PSP_CNT_W-1:0] cnt,
    input logic                 interleave
  );
    return interleave ? (base ^ cnt) : PSP_CNT_W'(base + cnt);
  endfunction

endpackage

`default_nettype wire

/* design/psp_fifo.sv */
// small flip-flop fifo with valid/ready on both sides
// assumes a synchronous active-high reset on the same clock
`default_nettype none

module psp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,   // clock
  input  wire logic             rst,       // sync reset, high
  input  wire logic             in_valid,  // writer offers a word
  output logic                  in_ready,  // room for a word
  input  wire logic [WIDTH-1:0] in_data,   // word written
  output logic                  out_valid, // head word present
  input  wire logic             out_ready, // reader takes head
  output logic      [WIDTH-1:0] out_data   // head word
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0]   count_reg;
  logic             push;
  logic             pop;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
  endfunction

  assign in_ready  = (count_reg != (PTR_W+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* design/psp_sram_ctrl.sv */
// pin-side logic of a pipelined burst sram: clock hold, byte writes,
// three chip selects, burst counter, two-stage command pipeline, array
// assumes controller pins share ref_clk; output enable and sleep are async
`default_nettype none

// How it works
// - clock hold high: edge ignored, read word kept; drive still follows output enable
// - each 9-bit lane has own write select
// - write selects ignored on read cycles
// - selected lanes written with data two cycles later
// - unselected chip on load starts deselect
// - bus released two cycles after deselect
// - selected only when all three selects asserted
// - all sampled on rising edge except output enable and sleep
// - write and read data both registered
// - order select high interleaved, low linear
// - output enable high forces data pins off
// - sleep high gates internal clock
// - array contents kept during sleep
// - advance steps burst counter, ignores address
// - load read/write level picks access, data later
// - load while deselected ends burst
// - one loaded address gives four words
module psp_sram_ctrl
  import psp_pkg::*;
#(
  parameter int ADDR_W     = PSP_ADDR_W,
  parameter int FIFO_DEPTH = PSP_FIFO_DEPTH
) (
  input  wire logic                  ref_clk,            // clock
  input  wire logic                  rst,                // sync reset, high
  input  wire logic                  clock_hold_n,       // high: edge ignored
  input  wire logic                  advance_or_load,    // high advance, low load
  input  wire logic                  read_not_write,     // high read, low write
  input  wire logic                  chip_select_low_a,  // select, active low
  input  wire logic                  chip_select_low_b,  // select, active low
  input  wire logic                  chip_select_high,   // select, active high
  input  wire logic [PSP_LANES-1:0]  byte_lane_write_n,  // lane write selects
  input  wire logic [ADDR_W-1:0]     address,            // word address
  input  wire logic                  burst_order_select, // high interleaved
  input  wire logic                  output_enable_n,    // async, low drives
  input  wire logic                  sleep_request,      // async sleep
  input  wire logic [PSP_DATA_W-1:0] data_lines_in,      // data pins in
  output logic      [PSP_DATA_W-1:0] data_lines_out,     // data pins out
  output logic                       data_lines_oe,      // data pins driven
  input  wire logic [PSP_PAR_W-1:0]  parity_lines_in,    // parity pins in
  output logic      [PSP_PAR_W-1:0]  parity_lines_out,   // parity pins out
  output logic                       parity_lines_oe,    // parity pins driven
  output logic                       write_room          // write buffer has room
);

  // array spans the whole address space; a narrower ADDR_W shrinks it
  localparam int DEPTH = 1 << ADDR_W;
  localparam int ENT_W = ADDR_W + PSP_LANES + PSP_WORD_W;

  // ==========================================================
  // lane helpers

  function automatic logic [PSP_WORD_W-1:0] lane_mask(
    input logic [PSP_LANES-1:0] bw_n
  );
    logic [PSP_WORD_W-1:0] m;
    m = '0;
    for (int i = 0; i < PSP_LANES; i++) begin
      m[i*PSP_BYTE_W +: PSP_BYTE_W] = {PSP_BYTE_W{!bw_n[i]}};
      m[PSP_DATA_W + i]             = !bw_n[i];
    end
    return m;
  endfunction

  function automatic logic [PSP_WORD_W-1:0] lane_merge(
    input logic [PSP_WORD_W-1:0] old_w,
    input logic [PSP_WORD_W-1:0] new_w,
    input logic [PSP_LANES-1:0]  bw_n
  );
    logic [PSP_WORD_W-1:0] m;
    m = lane_mask(bw_n);
    return (old_w & ~m) | (new_w & m);
  endfunction

  // ==========================================================
  // async inputs: two flip-flops each
  // other pins are taken as launched from ref_clk by the controller,
  // so they feed the decode with no synchroniser of their own

  logic [PSP_SYNC_STAGES-1:0] oe_n_sync_reg;
  logic [PSP_SYNC_STAGES-1:0] sleep_sync_reg;
  logic                       oe_n_s;
  logic                       sleep_s;

  // off-state constants keep the bus released while the chain fills
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      oe_n_sync_reg  <= {PSP_SYNC_STAGES{1'b1}};
      sleep_sync_reg <= {PSP_SYNC_STAGES{1'b0}};
    end else begin
      oe_n_sync_reg  <= {oe_n_sync_reg[0], output_enable_n};
      sleep_sync_reg <= {sleep_sync_reg[0], sleep_request};
    end
  end

  assign oe_n_s  = oe_n_sync_reg[PSP_SYNC_STAGES-1];
  assign sleep_s = sleep_sync_reg[PSP_SYNC_STAGES-1];

  // ==========================================================
  // state

  logic [PSP_WORD_W-1:0] mem_reg [0:DEPTH-1];

  logic                  burst_active_reg;
  logic                  burst_write_reg;
  logic [ADDR_W-1:0]     burst_base_reg;
  logic [PSP_CNT_W-1:0]  burst_cnt_reg;

  logic                  s1_valid_reg;
  logic                  s1_write_reg;
  logic [ADDR_W-1:0]     s1_addr_reg;
  logic [PSP_LANES-1:0]  s1_bw_n_reg;
  logic                  s2_valid_reg;
  logic                  s2_write_reg;
  logic [ADDR_W-1:0]     s2_addr_reg;
  logic [PSP_LANES-1:0]  s2_bw_n_reg;

  logic                  drive_reg;
  logic                  drive_next;
  logic [PSP_WORD_W-1:0] rd_word_reg;
  logic                  pins_oe_reg;
  logic                  room_reg;

  // ==========================================================
  // decode of the sampled pins

  logic                  fifo_in_ready;
  logic                  run;
  logic                  selected;
  logic                  do_load;
  logic                  do_deselect;
  logic                  do_step;
  logic                  issue;
  logic                  issue_write;
  logic [ADDR_W-1:0]     issue_addr;
  logic [PSP_LANES-1:0]  issue_bw_n;
  logic [PSP_CNT_W-1:0]  step_cnt;

  // a full write buffer stalls the pins exactly as clock hold does
  assign run = !clock_hold_n && !sleep_s && fifo_in_ready;

  assign selected = !chip_select_low_a && !chip_select_low_b
                  && chip_select_high;
  assign do_load     = !advance_or_load && selected;
  assign do_deselect = !advance_or_load && !selected;
  assign do_step     = advance_or_load && burst_active_reg;
  assign step_cnt    = PSP_CNT_W'(burst_cnt_reg + 1'b1);

  always_comb begin
    issue       = do_load || do_step;
    issue_write = do_load ? !read_not_write : burst_write_reg;
    if (do_load) begin
      issue_addr = address;
    end else begin
      issue_addr = {burst_base_reg[ADDR_W-1:PSP_CNT_W],
                    psp_burst_low(burst_base_reg[PSP_CNT_W-1:0], step_cnt,
                                  burst_order_select)};
    end
    // reads carry no lane selects down the pipe
    issue_bw_n = issue_write ? byte_lane_write_n : PSP_BW_NONE;
  end

  // ==========================================================
  // burst counter
  // a step with no burst open and a deselect with none are both no-ops

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      burst_active_reg <= 1'b0;
      burst_write_reg  <= 1'b0;
      burst_base_reg   <= '0;
      burst_cnt_reg    <= PSP_CNT_RST;
    end else if (run) begin
      if (do_load) begin
        burst_active_reg <= 1'b1;
        burst_write_reg  <= !read_not_write;
        burst_base_reg   <= address;
        burst_cnt_reg    <= PSP_CNT_RST;
      end else if (do_deselect) begin
        burst_active_reg <= 1'b0;
      end else if (do_step) begin
        // counter wraps modulo four, so a long burst revisits the block
        burst_cnt_reg <= step_cnt;
      end
    end
  end

  // ==========================================================
  // two-stage command pipeline

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_valid_reg <= 1'b0;
      s2_valid_reg <= 1'b0;
    end else if (run) begin
      // a deselect only stops new issue; staged commands still complete
      s1_valid_reg <= issue;
      s2_valid_reg <= s1_valid_reg;
    end
  end

  // payload moves with the valid bits; stale payload behind a bubble
  // is harmless since every consumer is gated by its valid bit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_write_reg <= 1'b0;
      s1_addr_reg  <= '0;
      s1_bw_n_reg  <= PSP_BW_NONE;
      s2_write_reg <= 1'b0;
      s2_addr_reg  <= '0;
      s2_bw_n_reg  <= PSP_BW_NONE;
    end else if (run) begin
      s1_write_reg <= issue_write;
      s1_addr_reg  <= issue_addr;
      s1_bw_n_reg  <= issue_bw_n;
      s2_write_reg <= s1_write_reg;
      s2_addr_reg  <= s1_addr_reg;
      s2_bw_n_reg  <= s1_bw_n_reg;
    end
  end

  // ==========================================================
  // write path: data captured two edges after its command

  logic                  wr_push;
  logic [ENT_W-1:0]      wr_entry;
  logic                  head_valid;
  logic [ENT_W-1:0]      head_entry;
  logic                  head_pop;
  logic [ADDR_W-1:0]     head_addr;
  logic [PSP_LANES-1:0]  head_bw_n;
  logic [PSP_WORD_W-1:0] head_word;

  assign wr_push  = run && s2_valid_reg && s2_write_reg;
  assign wr_entry = {s2_addr_reg, s2_bw_n_reg,
                     parity_lines_in, data_lines_in};

  // the array is left alone while asleep
  assign head_pop = !sleep_s;

  assign head_addr = head_entry[ENT_W-1 -: ADDR_W];
  assign head_bw_n = head_entry[PSP_WORD_W +: PSP_LANES];
  assign head_word = head_entry[PSP_WORD_W-1:0];

  psp_fifo #(
    .WIDTH (ENT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (wr_push),
    .in_ready  (fifo_in_ready),
    .in_data   (wr_entry),
    .out_valid (head_valid),
    .out_ready (head_pop),
    .out_data  (head_entry)
  );

  always_ff @(posedge ref_clk) begin
    if (head_valid && head_pop) begin
      mem_reg[head_addr] <= lane_merge(mem_reg[head_addr], head_word,
                                       head_bw_n);
    end
  end

  // ==========================================================
  // read path: registered word, driven the edge after two stages

  logic [PSP_WORD_W-1:0] rd_fetch;

  // only the head entry is forwarded; pushes and pops both stop in
  // sleep, so at most one entry is ever waiting when a read lands
  always_comb begin
    rd_fetch = mem_reg[s2_addr_reg];
    if (head_valid && head_addr == s2_addr_reg) begin
      rd_fetch = lane_merge(rd_fetch, head_word, head_bw_n);
    end
  end

  // bus drives only for a read in the last stage; a write or bubble
  // there releases it, which gives the two-cycle deselect
  assign drive_next = s2_valid_reg && !s2_write_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      drive_reg   <= 1'b0;
      rd_word_reg <= PSP_WORD_RST;
    end else if (run) begin
      drive_reg <= drive_next;
      if (drive_next) begin
        rd_word_reg <= rd_fetch;
      end
    end
  end

  // output enable is honoured even while the edge is held; its sync
  // chain costs two cycles of response time
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pins_oe_reg <= 1'b0;
    end else begin
      pins_oe_reg <= (run ? drive_next : drive_reg) && !oe_n_s;
    end
  end

  // one cycle late so the port comes straight from a flop; the buffer
  // holds at most one entry, since sleep stops pushes and pops together and a stall still pops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      room_reg <= 1'b0;
    end else begin
      room_reg <= fifo_in_ready;
    end
  end

  // ==========================================================
  // pins

  assign data_lines_out   = rd_word_reg[PSP_DATA_W-1:0];
  assign parity_lines_out = rd_word_reg[PSP_WORD_W-1:PSP_DATA_W];
  // parity pins share the data enable: each lane is one 9-bit unit
  assign data_lines_oe    = pins_oe_reg;
  assign parity_lines_oe  = pins_oe_reg;
  assign write_room       = room_reg;

endmodule

`default_nettype wire

/* bench/psp_sram_ctrl_monitor.sv */
// checker on the pin-control block's ports: drive enable and freeze
// assumes pins change just after the rising edge of ref_clk
`default_nettype none
module psp_sram_ctrl_monitor
  import psp_pkg::*;
(
  input wire logic                  ref_clk,           // clock
  input wire logic                  rst,               // reset
  input wire logic                  clock_hold_n,      // hold
  input wire logic                  advance_or_load,   // step/load
  input wire logic                  read_not_write,    // rd/wr
  input wire logic                  chip_select_low_a, // cs a
  input wire logic                  chip_select_low_b, // cs b
  input wire logic                  chip_select_high,  // cs hi
  input wire logic                  output_enable_n,   // oe pin
  input wire logic                  sleep_request,     // sleep
  input wire logic [PSP_DATA_W-1:0] data_lines_out,    // read word
  input wire logic                  data_lines_oe      // drive
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // decoded commands
  logic       run, ld, dsl, rd_ld, wr_ld;
  logic [1:0] slp_q;
  // sleep reaches the pipeline through the block's own two flip-flops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      slp_q <= 2'h0;
    end else begin
      slp_q <= {slp_q[0], sleep_request};
    end
  end
  assign run   = !clock_hold_n && !slp_q[1];
  assign ld    = run && !advance_or_load;
  assign dsl   = ld && !(!chip_select_low_a && !chip_select_low_b && chip_select_high);
  assign rd_ld = ld && !dsl && read_not_write;
  assign wr_ld = ld && !dsl && !read_not_write;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // assertions
  property p_oe_off; output_enable_n [*3] |=> !data_lines_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("drive while disabled");
  property p_hold; clock_hold_n |=> $stable(data_lines_out); endproperty
  a_hold: assert property (p_hold) else $error("word moved on held edge");
  property p_rd; rd_ld && !output_enable_n ##1 run ##1 run |=> data_lines_oe; endproperty
  a_rd: assert property (p_rd) else $error("read not driven");
  property p_wr; wr_ld ##1 run ##1 run |=> !data_lines_oe; endproperty
  a_wr: assert property (p_wr) else $error("driven in write slot");
  property p_dsl; dsl ##1 run ##1 run |=> !data_lines_oe; endproperty
  a_dsl: assert property (p_dsl) else $error("bus kept after deselect");
  property p_csh;
    ld && read_not_write && !chip_select_high && !chip_select_low_a && !chip_select_low_b
    ##1 run ##1 run |=> !data_lines_oe;
  endproperty
  a_csh: assert property (p_csh) else $error("read with high select off");
  property p_stp;
    rd_ld ##1 (run && advance_or_load && !output_enable_n) ##1 run ##1 run |=> data_lines_oe;
  endproperty
  a_stp: assert property (p_stp) else $error("burst step not driven");
  property p_frz; (!output_enable_n) [*4] ##0 clock_hold_n |=> $stable(data_lines_oe); endproperty
  a_frz: assert property (p_frz) else $error("enable moved on held edge");
  c_rd: cover property (rd_ld ##3 data_lines_oe);
  c_wr: cover property (wr_ld);
  c_frz: cover property (clock_hold_n ##1 clock_hold_n);
endmodule

bind psp_sram_ctrl psp_sram_ctrl_monitor u_psp_sram_ctrl_monitor (.*);
`default_nettype wire

/* bench/psp_ctrl_model.sv */
// memory controller model: bench requests become pin levels, data two run edges on
// assumes requests change 1 ns after the rising edge of ref_clk
`default_nettype none
module psp_ctrl_model
  import psp_pkg::*;
(
  input  wire logic                  ref_clk,           // clock
  input  wire logic [1:0]            op,                // idle rd wr step
  input  wire logic                  hold,              // stall edge
  input  wire logic [3:0]            addr,              // word
  input  wire logic [PSP_LANES-1:0]  bw_n,              // lanes
  input  wire logic [PSP_WORD_W-1:0] wdata,             // write word
  output logic                       clock_hold_n,      // hold
  output logic                       advance_or_load,   // step
  output logic                       read_not_write,    // rd
  output logic                       chip_select_low_a, // cs a
  output logic                       chip_select_low_b, // cs b
  output logic                       chip_select_high,  // cs hi
  output logic      [PSP_LANES-1:0]  byte_lane_write_n, // lanes
  output logic      [17:0]           address,           // word
  output logic      [PSP_DATA_W-1:0] data_lines_in,     // data
  output logic      [PSP_PAR_W-1:0]  parity_lines_in    // parity
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [PSP_WORD_W-1:0] due = '0;
  logic [PSP_WORD_W-1:0] din = '0;
  logic                  due_v = 1'b0;
  logic                  b_on = 1'b0;
  logic                  b_wr = 1'b0;
  logic                  idle;
  assign idle = (op == 2'h0);
  assign clock_hold_n = hold;
  assign advance_or_load = (op == 2'h3);
  assign read_not_write = (op != 2'h2);
  // idle rotates which select is dropped
  assign chip_select_low_a = idle && (addr[1:0] == 2'h0);
  assign chip_select_low_b = idle && (addr[1:0] == 2'h1);
  assign chip_select_high = !(idle && addr[1]);
  assign byte_lane_write_n = bw_n;
  assign address = {14'h0, addr};
  assign {parity_lines_in, data_lines_in} = din;
  // ==========================================================
  // write data lands one run edge after the command edge
  always @(posedge ref_clk) begin
    if (!hold) begin
      din <= #1 due_v ? due : ~din; // no stale word left on an idle bus
      due_v <= #1 (op == 2'h2) || (op == 2'h3 && b_on && b_wr);
      due <= #1 wdata;
      if (op != 2'h3) begin
        b_on <= #1 !idle;
        b_wr <= #1 (op == 2'h2);
      end
    end
  end
endmodule
`default_nettype wire

/* bench/tb_pipelined_sram_pin_control.sv */
// bench: random pin traffic from the controller model against a reference model
// assumes read word and drive enable settle between rising edges
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_pipelined_sram_pin_control;
  timeunit 1ns;
  timeprecision 1ns;
  import psp_pkg::*;
  logic                  ref_clk = 1'b0, rst = 1'b1, hold = 1'b0, output_enable_n = 1'b0;
  logic                  sleep_request = 1'b0, burst_order_select = 1'b0, exp_oe = 1'b0;
  logic [1:0]            op = 2'h0, cnt;
  logic [3:0]            addr = 4'h0, bw_n = 4'hf, s1_a, s2_a, s1_bw, s2_bw, base;
  logic [PSP_WORD_W-1:0] wdata = '0, exp_d, w;
  logic [PSP_WORD_W-1:0] mem [16];
  logic [2:0]            oeh, slh;
  logic                  exp_room = 1'b0;
  logic                  s1_rd, s1_wr, s2_rd, s2_wr, b_on, b_rd, exp_rd;
  logic                  clock_hold_n, advance_or_load, read_not_write, chip_select_high;
  logic                  chip_select_low_a, chip_select_low_b, data_lines_oe;
  logic                  parity_lines_oe, write_room;
  logic [PSP_LANES-1:0]  byte_lane_write_n;
  logic [PSP_ADDR_W-1:0] address;
  logic [PSP_DATA_W-1:0] data_lines_in, data_lines_out;
  logic [PSP_PAR_W-1:0]  parity_lines_in, parity_lines_out;
  int                    seed = 55500, num_errors = 0, cmp_count = 0, r;
  psp_sram_ctrl  u_psp_sram_ctrl (.*);
  psp_ctrl_model u_psp_ctrl_model (.*);
  initial forever #50 ref_clk = ~ref_clk;
  // ==========================================================
  // reference model: check last edge's result, then take this edge
  always @(posedge ref_clk) begin
    if (!rst) begin
      `CHK("oe", exp_oe, data_lines_oe)
      `CHK("poe", exp_oe, parity_lines_oe)
      `CHK("room", exp_room, write_room)
      if (exp_oe === 1'b1) `CHK("rd", exp_d, {parity_lines_out, data_lines_out})
    end
    oeh = {oeh[1:0], output_enable_n};
    slh = {slh[1:0], sleep_request};
    if (rst) begin
      {s1_rd, s1_wr, s2_rd, s2_wr, b_on, exp_rd} = '0;
      oeh = 3'h7;
      slh = 3'h0;
    end else if (!clock_hold_n && !slh[2]) begin
      if (s2_wr) begin
        w = mem[s2_a];
        for (int i = 0; i < 4; i++)
          if (!s2_bw[i]) w[8*i +: 8] = data_lines_in[8*i +: 8];
        for (int i = 0; i < 4; i++)
          if (!s2_bw[i]) w[32+i] = parity_lines_in[i];
        mem[s2_a] = w;
      end
      exp_rd = s2_rd;
      exp_d = mem[s2_a];
      {s2_rd, s2_wr, s2_a, s2_bw} = {s1_rd, s1_wr, s1_a, s1_bw};
      {s1_rd, s1_wr} = 2'h0;
      if (!advance_or_load) begin
        b_on = !chip_select_low_a && !chip_select_low_b && chip_select_high;
        b_rd = read_not_write;
        base = address[3:0];
        cnt = 2'h0;
      end else cnt = cnt + 2'h1;
      if (b_on) begin
        s1_rd = b_rd;
        s1_wr = !b_rd;
        s1_a = {base[3:2], burst_order_select ? base[1:0] ^ cnt : base[1:0] + cnt};
        s1_bw = byte_lane_write_n;
      end
    end
    exp_oe = exp_rd && !oeh[2];
    exp_room = !rst;
  end
  task automatic drv(input logic [1:0] o, input logic h, input logic [3:0] a, b);
    @(posedge ref_clk);
    #1;
    op = o;
    hold = h;
    addr = a;
    bw_n = b;
    wdata = 36'({$random(seed), $random(seed)});
  endtask
  task automatic stop_test();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // two passes, one per burst order, reset between them
  initial begin
    for (int ph = 0; ph < 2; ph++) begin
      drv(2'h0, 1'b0, 4'h2, 4'hf);
      rst = 1'b1;
      burst_order_select = ph[0];
      repeat (4) drv(2'h0, 1'b0, 4'h2, 4'hf);
      rst = 1'b0;
      for (int a = 0; a < 16; a++) drv(2'h2, 1'b0, 4'(a), 4'h0);
      repeat (400) begin
        r = $random(seed);
        drv(2'(r), r[5:3] == 3'h0, 4'(r >> 8), 4'(r >> 12));
        if (r[31:27] == 5'h0) output_enable_n = ~output_enable_n;
      end
      output_enable_n = 1'b0;
      repeat (4) drv(2'h0, 1'b0, 4'h2, 4'hf);
      sleep_request = 1'b1;
      repeat (3) drv(2'h0, 1'b0, 4'h2, 4'hf);
      repeat (6) drv(2'h2, 1'b0, 4'($random(seed)), 4'h0);
      drv(2'h0, 1'b0, 4'h2, 4'hf);
      sleep_request = 1'b0;
      repeat (4) drv(2'h0, 1'b0, 4'h2, 4'hf);
      for (int a = 0; a < 16; a++) drv(2'h1, 1'b0, 4'(a), 4'h0);
      repeat (4) drv(2'h0, 1'b0, 4'h2, 4'hf);
    end
    stop_test();
  end
  initial begin
    #1000000;
    num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
